// File: design/boot_strap_defs.vh
`ifndef BOOT_STRAP_DEFS_VH
`define BOOT_STRAP_DEFS_VH

// strap field positions
`define STRAP_XTAL_HI        15
`define STRAP_XTAL_LO        14
`define STRAP_RSVD_HI        13
`define STRAP_RSVD_LO        12
`define STRAP_AUXCLK_BIT     5
`define STRAP_SEQ_HI         4
`define STRAP_SEQ_LO         0

// crystal codes and reserved field value
`define XTAL_19M2            2'h0
`define XTAL_24M             2'h1
`define XTAL_25M             2'h2
`define XTAL_26M             2'h3
`define STRAP_RSVD_OK        2'h0

// sequence select values
`define SEQ_DEFAULT          5'h1C
`define SEQ_ALTERNATE        5'h18

// boot source codes
`define SRC_NONE             3'h0
`define SRC_EMBEDDED_FLASH   3'h1
`define SRC_REMOVABLE_CARD   3'h2
`define SRC_SERIAL_FLASH     3'h3
`define SRC_SERIAL_CONSOLE   3'h4
`define SRC_USB_DEVICE       3'h5

// raw image probe and embedded flash bus width
`define RAW_PROBE_COUNT      3'h4
`define RAW_SECTOR_STEP      10'h100
`define RAW_IMAGE_STEP       20'h20000
`define EMB_FLASH_BUS_WIDTH  4'h4

// reset values
`define RST_STRAPS           16'h0000
`define RST_SOURCE           3'h0

`endif

// File: design/boot_order_rom.v
`timescale 1ns/100ps
`default_nettype none
`include "boot_strap_defs.vh"

// small registered table of boot order per sequence
module boot_order_rom (
	input  wire       clk,     // clock
	input  wire       ce,      // clock enable
	input  wire       alt_seq, // alternate sequence selected
	input  wire [1:0] slot,    // position in sequence
	output reg  [2:0] source   // boot source at that position
);
	always @(posedge clk) begin
		if (ce) begin
			case ({alt_seq, slot})
			3'h0: source <= `SRC_EMBEDDED_FLASH;
			3'h1: source <= `SRC_REMOVABLE_CARD;
			3'h2: source <= `SRC_SERIAL_CONSOLE;
			3'h3: source <= `SRC_USB_DEVICE;
			3'h4: source <= `SRC_SERIAL_FLASH;
			3'h5: source <= `SRC_REMOVABLE_CARD;
			3'h6: source <= `SRC_USB_DEVICE;
			default: source <= `SRC_SERIAL_CONSOLE;
			endcase
		end
	end
endmodule

`default_nettype wire

// File: design/boot_strap_sequence_select.v
`timescale 1ns/100ps
`default_nettype none
`include "boot_strap_defs.vh"

module boot_strap_sequence_select #(
	parameter SLOT_COUNT = 4,                // sources in one boot sequence
	parameter RAW_PROBES = `RAW_PROBE_COUNT  // sectors probed on a raw source
) (
	input  wire        clk,              // 250 MHz clock
	input  wire        rst_n,            // synchronous reset, active low
	input  wire        ce,               // clock enable
	input  wire [15:0] boot_strap_pins,  // strap pin levels (async)
	input  wire        source_present,   // current source exists (same clock)
	input  wire        image_found,      // header found at current probe
	input  wire        probe_done,       // probe answer valid, one pulse
	output reg  [1:0]  xtal_sel,         // crystal frequency code
	output reg         aux_clock_output, // auxiliary clock enable
	output reg         strap_error,      // reserved strap value or unknown sequence
	output reg  [2:0]  boot_source,      // source being tried
	output reg  [9:0]  probe_sector,     // raw sector to read
	output reg  [3:0]  bus_width,        // embedded flash bus width
	output reg         probe_req,        // request probe of current sector
	output reg         boot_ok,          // image located
	output reg         boot_failed       // all sources exhausted, or straps rejected
);
	localparam ST_SAMPLE = 3'h0;
	localparam ST_LOAD   = 3'h1;
	localparam ST_WAIT   = 3'h2;
	localparam ST_PROBE  = 3'h3;
	localparam ST_ANS    = 3'h4;
	localparam ST_DONE   = 3'h5;

	reg [15:0] sync1;
	reg [15:0] sync2;
	reg [15:0] straps;
	reg        alt_seq;
	reg [2:0]  state;
	reg [1:0]  slot;
	reg [2:0]  probe_idx;
	reg        seq_valid;
	wire [2:0] rom_source;
	wire       capture;
	reg  [2:0] next_state;
	reg  [1:0] next_slot;
	reg  [2:0] next_probe_idx;
	reg  [2:0] next_boot_source;
	reg  [9:0] next_probe_sector;
	reg        next_probe_req;
	reg        next_boot_ok;
	reg        next_boot_failed;
	genvar     i;

	function is_raw_source;
		input [2:0] s;
		begin
			is_raw_source = (s == `SRC_EMBEDDED_FLASH) || (s == `SRC_REMOVABLE_CARD);
		end
	endfunction

	function seq_is_alt;
		input [4:0] code;
		begin
			seq_is_alt = (code == `SEQ_ALTERNATE);
		end
	endfunction

	function seq_is_known;
		input [4:0] code;
		begin
			seq_is_known = (code == `SEQ_DEFAULT) || (code == `SEQ_ALTERNATE);
		end
	endfunction

	function reserved_clear;
		input [1:0] field;
		begin
			reserved_clear = (field == `STRAP_RSVD_OK);
		end
	endfunction

	boot_order_rom u_rom (
		.clk     (clk),
		.ce      (ce),
		.alt_seq (alt_seq),
		.slot    (slot),
		.source  (rom_source)
	);

	generate
		for (i = 0; i < 16; i = i + 1) begin : g_sync
			// two flops per pin; only the second stage is read by logic
			always @(posedge clk) begin
				if (ce) begin
					sync1[i] <= boot_strap_pins[i];
					sync2[i] <= sync1[i];
				end
			end
		end
	endgenerate

	assign capture = (state == ST_SAMPLE);

	// taken once after release; pins ignored until the next reset
	always @(posedge clk) begin
		if (ce) begin
			if (!rst_n) begin
				straps           <= `RST_STRAPS;
				alt_seq          <= 1'b0;
				seq_valid        <= 1'b0;
				xtal_sel         <= `XTAL_19M2;
				aux_clock_output <= 1'b0;
				strap_error      <= 1'b0;
			end else if (capture) begin
				straps           <= sync2;
				xtal_sel         <= sync2[`STRAP_XTAL_HI:`STRAP_XTAL_LO];
				aux_clock_output <= sync2[`STRAP_AUXCLK_BIT];
				alt_seq          <= seq_is_alt(sync2[`STRAP_SEQ_HI:`STRAP_SEQ_LO]);
				seq_valid        <= seq_is_known(sync2[`STRAP_SEQ_HI:`STRAP_SEQ_LO]);
				// bits 11:6 are never looked at
				strap_error      <= !reserved_clear(sync2[`STRAP_RSVD_HI:`STRAP_RSVD_LO]) ||
					!seq_is_known(sync2[`STRAP_SEQ_HI:`STRAP_SEQ_LO]);
			end
		end
	end

	always @* begin
		next_state        = state;
		next_slot         = slot;
		next_probe_idx    = probe_idx;
		next_boot_source  = boot_source;
		next_probe_sector = probe_sector;
		next_probe_req    = 1'b0;
		next_boot_ok      = boot_ok;
		next_boot_failed  = boot_failed;
		case (state)
		ST_SAMPLE: begin
			next_slot  = 2'h0;
			next_state = ST_LOAD;
		end
		ST_LOAD: begin
			// unknown sequence codes boot nothing rather than guess
			if (!seq_valid || strap_error) begin
				next_boot_failed = 1'b1;
				next_state       = ST_DONE;
			end else begin
				next_state = ST_WAIT;
			end
		end
		ST_WAIT: begin
			// the order table is registered, so the slot was applied one state earlier
			next_boot_source  = rom_source;
			next_probe_idx    = 3'h0;
			next_probe_sector = 10'h000;
			next_state        = ST_PROBE;
		end
		ST_PROBE: begin
			next_probe_req = 1'b1;
			next_state     = ST_ANS;
		end
		ST_ANS: begin
			if (probe_done) begin
				if (source_present && image_found) begin
					next_boot_ok = 1'b1;
					next_state   = ST_DONE;
				end else if (source_present && is_raw_source(boot_source) &&
					(probe_idx != RAW_PROBES - 1)) begin
					next_probe_idx    = probe_idx + 3'h1;
					next_probe_sector = probe_sector + `RAW_SECTOR_STEP;
					next_state        = ST_PROBE;
				end else if (slot == SLOT_COUNT - 1) begin
					next_boot_failed = 1'b1;
					next_state       = ST_DONE;
				end else begin
					next_slot  = slot + 2'h1;
					next_state = ST_LOAD;
				end
			end
		end
		ST_DONE: begin
			// verdict holds until the next reset
			next_state = ST_DONE;
		end
		default: next_state = ST_DONE;
		endcase
	end

	always @(posedge clk) begin
		if (ce) begin
			if (!rst_n) begin
				state        <= ST_SAMPLE;
				slot         <= 2'h0;
				probe_idx    <= 3'h0;
				boot_source  <= `RST_SOURCE;
				probe_sector <= 10'h000;
				bus_width    <= `EMB_FLASH_BUS_WIDTH;
				probe_req    <= 1'b0;
				boot_ok      <= 1'b0;
				boot_failed  <= 1'b0;
			end else begin
				state        <= next_state;
				slot         <= next_slot;
				probe_idx    <= next_probe_idx;
				boot_source  <= next_boot_source;
				probe_sector <= next_probe_sector;
				// boot only ever uses the narrow bus; widening is left to later software
				bus_width    <= `EMB_FLASH_BUS_WIDTH;
				probe_req    <= next_probe_req;
				boot_ok      <= next_boot_ok;
				boot_failed  <= next_boot_failed;
			end
		end
	end
endmodule

`default_nettype wire

// File: test/boot_media_model.sv
`timescale 1ns/100ps
`default_nettype none
module boot_media_model (
	input  wire logic       clk,            // clock
	input  wire logic       probe_req,      // probe request
	input  wire logic [2:0] boot_source,    // source asked
	input  wire logic [9:0] probe_sector,   // sector asked
	input  wire logic [7:0] present,        // sources fitted
	input  wire logic [2:0] hit_src,        // source with image
	input  wire logic [9:0] hit_sec,        // sector with image
	input  wire logic [3:0] delay,          // answer delay
	output logic            source_present, // source exists
	output logic            image_found,    // header found
	output logic            probe_done      // answer pulse
);
	logic [3:0] cnt;
	logic       busy;
	initial begin
		busy = 1'b0;
		cnt = 4'h0;
		probe_done = 1'b0;
		source_present = 1'b0;
		image_found = 1'b0;
	end
	// presence and image lines toggle outside a reply, probe_done stays low, so a stale read never looks valid
	always @(posedge clk) begin
		probe_done <= 1'b0;
		source_present <= ~source_present;
		image_found <= ~image_found;
		if (probe_req) begin
			busy <= 1'b1;
			cnt <= delay;
		end else if (busy && cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end else if (busy) begin
			busy <= 1'b0;
			probe_done <= 1'b1;
			source_present <= present[boot_source];
			image_found <= boot_source == hit_src && probe_sector == hit_sec;
		end
	end
endmodule
`default_nettype wire

// File: test/boot_strap_checker.sv
`timescale 1ns/100ps
`default_nettype none
module boot_strap_checker (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       ce,
	input wire logic       source_present,
	input wire logic       image_found,
	input wire logic       probe_done,
	input wire logic [1:0] xtal_sel,
	input wire logic       aux_clock_output,
	input wire logic       strap_error,
	input wire logic [2:0] boot_source,
	input wire logic [9:0] probe_sector,
	input wire logic [3:0] bus_width,
	input wire logic       probe_req,
	input wire logic       boot_ok,
	input wire logic       boot_failed
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	width_four_a: assert property (bus_width == 4'h4) else $error("width");
	straps_held_a: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |->
		$stable({xtal_sel, aux_clock_output, strap_error})) else $error("straps moved");
	error_block_a: assert property (strap_error |-> !probe_req && !boot_ok) else $error("error");
	req_pulse_a: assert property (probe_req |=> !probe_req) else $error("req");
	sector_set_a: assert property (probe_req |-> probe_sector[7:0] == 8'h00 &&
		(boot_source inside {3'h1, 3'h2} || probe_sector == 10'h000)) else $error("sector");
	ok_sticky_a: assert property (boot_ok |=> boot_ok && !probe_req) else $error("ok");
	fail_sticky_a: assert property (boot_failed |=> boot_failed && !boot_ok) else $error("fail");
	found_ok_a: assert property (ce && probe_done && source_present && image_found |=> boot_ok) else $error("found");
	fall_next_a: assert property (ce && probe_done && !source_present |-> ##[1:6] probe_req || boot_failed) else $error("next");
	cover property (boot_ok);
	cover property (boot_failed && !strap_error);
	cover property (probe_req && probe_sector == 10'h300);
endmodule
bind boot_strap_sequence_select boot_strap_checker chk (.clk, .rst_n, .ce, .source_present, .image_found,
	.probe_done, .xtal_sel, .aux_clock_output, .strap_error, .boot_source, .probe_sector, .bus_width,
	.probe_req, .boot_ok, .boot_failed);
`default_nettype wire

// File: test/boot_strap_sequence_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
module boot_strap_sequence_select_tb;
	logic        clk, rst_n, ce, source_present, image_found, probe_done, aux_clock_output;
	logic        strap_error, probe_req, boot_ok, boot_failed;
	logic [15:0] boot_strap_pins;
	logic [1:0]  xtal_sel;
	logic [2:0]  boot_source, hit_src;
	logic [9:0]  probe_sector, hit_sec;
	logic [3:0]  bus_width, delay;
	logic [7:0]  present;
	logic [23:0] log_src;
	int          fails, tests_run;
	boot_strap_sequence_select uut (.clk, .rst_n, .ce, .boot_strap_pins, .source_present, .image_found,
		.probe_done, .xtal_sel, .aux_clock_output, .strap_error, .boot_source, .probe_sector, .bus_width,
		.probe_req, .boot_ok, .boot_failed);
	boot_media_model media (.clk, .probe_req, .boot_source, .probe_sector, .present, .hit_src, .hit_sec,
		.delay, .source_present, .image_found, .probe_done);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) log_src <= !rst_n ? 24'h0 : probe_req ? {log_src[20:0], boot_source} : log_src;
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic run(input logic [15:0] p, input logic [7:0] pr, input logic [2:0] hs, input logic [9:0] hc,
		input logic [3:0] d);
		@(posedge clk);
		rst_n <= 1'b0;
		boot_strap_pins <= p;
		present <= pr;
		hit_src <= hs;
		hit_sec <= hc;
		delay <= d;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 300 && !(boot_ok || boot_failed); i++) @(negedge clk);
	endtask
	task automatic t_default;
		run(16'h0FFC, 8'h32, 3'h4, 10'h000, 4'h0);
		chk("order", 24'h009254, log_src);
		chk("ok", 24'h1, boot_ok);
		chk("xtal aux width", 24'h014, {xtal_sel, aux_clock_output, bus_width});
	endtask
	task automatic t_alt;
		run(16'hC018, 8'h24, 3'h5, 10'h000, 4'h2);
		chk("order", 24'h01A495, log_src);
		chk("xtal aux ok", 24'hD, {xtal_sel, aux_clock_output, boot_ok});
	endtask
	task automatic t_raw;
		run(16'h401C, 8'h02, 3'h1, 10'h300, 4'h3);
		chk("order", 24'h000249, log_src);
		chk("xtal ok", 24'h3, {xtal_sel, boot_ok});
	endtask
	task automatic t_fail;
		run(16'h801C, 8'h00, 3'h0, 10'h000, 4'h1);
		chk("order", 24'h0002A5, log_src);
		@(posedge clk);
		boot_strap_pins <= 16'h3FFF;
		repeat (5) @(negedge clk);
		chk("held", 24'h9, {xtal_sel, strap_error, boot_failed});
		@(posedge clk);
		ce <= 1'b0;
		rst_n <= 1'b0;
		repeat (4) @(negedge clk);
		chk("frozen", 24'h9, {xtal_sel, strap_error, boot_failed});
		@(posedge clk);
		ce <= 1'b1;
	endtask
	task automatic t_rsvd;
		run(16'h101C, 8'h3E, 3'h1, 10'h000, 4'h0);
		chk("no probes", 24'h0, log_src);
		chk("reserved", 24'h3, {22'h0, strap_error, boot_failed});
	endtask
	task automatic final_report;
		$display("checks %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		fails++;
		final_report;
	end
	initial begin
		{rst_n, boot_strap_pins, present, hit_src, hit_sec, delay} = '0;
		ce = 1'b1;
		fails = 0;
		tests_run = 0;
		t_default;
		t_alt;
		t_raw;
		t_fail;
		t_rsvd;
		final_report;
	end
endmodule
`default_nettype wire
